/* File: hdl/vtw_pkg.sv */
/*
 * Constants shared by the VLAN table staging register block: register
 * numbers, field positions, table sizes and reset values.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package vtw_pkg;
    // --------------------------------------------------------------
    // register numbers
    // --------------------------------------------------------------
    localparam logic [15:0] REG_CMD      = 16'h180B;
    localparam logic [15:0] REG_WR_DATA  = 16'h180C;
    localparam logic [15:0] REG_RD_DATA  = 16'h180E;
    localparam logic [15:0] REG_CMD_STS  = 16'h1810;

    // --------------------------------------------------------------
    // field layout
    // --------------------------------------------------------------
    localparam int DATA_W       = 18;   // live width of data registers
    localparam int VID_W        = 12;
    localparam int PRIO_W       = 3;
    localparam int PVID_W       = 15;   // vid plus priority
    localparam int VID_LSB      = 0;
    localparam int PRIO_LSB     = 12;
    localparam int P0_UNTAG_BIT = 12;   // port p untag at 12+2p, member at 13+2p
    localparam int CMD_IDX_W    = 4;
    localparam int CMD_SEL_BIT  = 4;    // set: port default table
    localparam int CMD_RNW_BIT  = 5;    // set: read, clear: write
    localparam int CMD_W        = 6;
    localparam int STS_PEND_BIT = 0;

    // --------------------------------------------------------------
    // sizes and reset values
    // --------------------------------------------------------------
    localparam int NUM_ENTRIES  = 16;
    localparam int NUM_PORTS    = 3;
    localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
    localparam logic [PVID_W-1:0] PVID_RST = 15'h0000;
    localparam logic [CMD_W-1:0]  CMD_RST  = 6'h00;
    localparam logic [VID_W-1:0]  VID_NULL = 12'h000;
endpackage : vtw_pkg

/* File: hdl/vtw_entry_match.sv */
/*
 * Compares one stored VLAN entry against a lookup VLAN ID.
 * Assumes the entry layout of vtw_pkg; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module vtw_entry_match (
    // stored entry
    input  wire logic [vtw_pkg::DATA_W-1:0] entry,
    // vid under lookup
    input  wire logic [vtw_pkg::VID_W-1:0]  vid,
    // result
    output logic                            hit
);
    assign hit = (entry[vtw_pkg::VID_W-1:0] != vtw_pkg::VID_NULL) &&
                 (entry[vtw_pkg::VID_W-1:0] == vid);
endmodule : vtw_entry_match
`default_nettype wire

/* File: hdl/vtw_vlan_table.sv */
/*
 * VLAN table write-data staging register with the command register,
 * operation-pending status, read-data register, the VLAN and port
 * default tables and the per-frame lookup that applies them.
 * Assumes a same-clock register port from the management logic and a
 * same-clock lookup strobe from the forwarding logic.
 */
// Functional notes
// - table select clear: data is a VLAN entry; set: port default entry
// - port default: vid in bits 11:0, priority in 14:12, rest reserved
// - untagged or null-vid frames take the port's default vid and priority
// - port default vid and priority reset to zero on all three ports
// - member bit set: matching ingress frames accepted on that port
// - member bit clear: matching frames dropped unless admit-nonmember set
// - egress broadcast domain holds only ports whose member bit is set
// - ingress port's untag bit set: tag stripped when member hybrid egress ports transmit
// - member/untag pairs at 17:16 port2, 15:14 port1, 13:12 port0
// - entry vid is bits 11:0, reset zero
// - entry vid zero means entry disabled
// - command write starts access at once; bit 5 read one, write zero; a command write while pending is ignored
// - command bit 4 picks port table; bits 3:0 pick entry or port
`timescale 1ns/1ps
`default_nettype none
module vtw_vlan_table (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    output logic             reg_rvalid,
    // per-port settings kept elsewhere
    input  wire logic [2:0]  admit_nonmember_config,
    input  wire logic [2:0]  egress_port_kind_config,
    // lookup request
    input  wire logic        lk_req,
    input  wire logic [1:0]  lk_port,
    input  wire logic        lk_tagged,
    input  wire logic [11:0] lk_vid,
    input  wire logic [2:0]  lk_prio,
    // lookup answer
    output logic             lk_done,
    output logic             lk_accept,
    output logic [11:0]      lk_vid_out,
    output logic [2:0]       lk_prio_out,
    output logic [2:0]       lk_member_mask,
    output logic [2:0]       lk_strip_mask
);
    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [vtw_pkg::DATA_W-1:0] vlan_table_write_data_q;
    logic [vtw_pkg::DATA_W-1:0] rd_data_q;
    logic [vtw_pkg::CMD_W-1:0]  vlan_table_command_q;
    logic                       pend_q;
    logic [vtw_pkg::DATA_W-1:0] vtab_q [vtw_pkg::NUM_ENTRIES];
    logic [vtw_pkg::PVID_W-1:0] pvid_q [vtw_pkg::NUM_PORTS];

    logic                       wr_cmd;
    logic [3:0]                 cmd_idx;
    logic                       table_select_port_default;
    logic                       table_read_not_write;

    assign wr_cmd  = reg_wr && (reg_addr == vtw_pkg::REG_CMD) && !pend_q;
    assign cmd_idx = vlan_table_command_q[vtw_pkg::CMD_IDX_W-1:0];
    assign table_select_port_default = vlan_table_command_q[vtw_pkg::CMD_SEL_BIT];
    assign table_read_not_write      = vlan_table_command_q[vtw_pkg::CMD_RNW_BIT];

    // ----------------------------------------------------------------
    // staging and command registers
    // ----------------------------------------------------------------
    // staging register; upper bits never stored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            vlan_table_write_data_q <= vtw_pkg::DATA_RST;
        end else if (reg_wr && reg_addr == vtw_pkg::REG_WR_DATA) begin
            vlan_table_write_data_q <= reg_wdata[vtw_pkg::DATA_W-1:0];
        end
    end

    // command capture; a write while pending is ignored so the
    // running access never sees its index change underneath it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            vlan_table_command_q <= vtw_pkg::CMD_RST;
            pend_q               <= 1'b0;
        end else if (wr_cmd) begin
            vlan_table_command_q <= reg_wdata[vtw_pkg::CMD_W-1:0];
            pend_q               <= 1'b1;
        end else begin
            pend_q <= 1'b0;                  // access completes in one cycle
        end
    end

    // ----------------------------------------------------------------
    // table access
    // ----------------------------------------------------------------
    // select table by mode
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < vtw_pkg::NUM_ENTRIES; i++) begin
                vtab_q[i] <= vtw_pkg::DATA_RST;
            end
        end else if (pend_q && !table_read_not_write && !table_select_port_default) begin
            vtab_q[cmd_idx] <= vlan_table_write_data_q;
        end
    end

    // port defaults; out-of-range port index is ignored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int p = 0; p < vtw_pkg::NUM_PORTS; p++) begin
                pvid_q[p] <= vtw_pkg::PVID_RST;
            end
        end else if (pend_q && !table_read_not_write && table_select_port_default &&
                     cmd_idx < 4'(vtw_pkg::NUM_PORTS)) begin
            pvid_q[cmd_idx[1:0]] <= vlan_table_write_data_q[vtw_pkg::PVID_W-1:0];
        end
    end

    // read access result
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= vtw_pkg::DATA_RST;
        end else if (pend_q && table_read_not_write) begin
            if (!table_select_port_default) begin
                rd_data_q <= vtab_q[cmd_idx];
            end else if (cmd_idx < 4'(vtw_pkg::NUM_PORTS)) begin
                rd_data_q <= {3'h0, pvid_q[cmd_idx[1:0]]};
            end else begin
                rd_data_q <= vtw_pkg::DATA_RST;
            end
        end
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    // one cycle read latency; unmapped numbers read zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata  <= 32'h00000000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                unique case (reg_addr)
                    vtw_pkg::REG_WR_DATA: reg_rdata <= {14'h0000, vlan_table_write_data_q};
                    vtw_pkg::REG_RD_DATA: reg_rdata <= {14'h0000, rd_data_q};
                    vtw_pkg::REG_CMD:     reg_rdata <= {26'h0000000, vlan_table_command_q};
                    vtw_pkg::REG_CMD_STS: reg_rdata <= {31'h00000000, pend_q};
                    default:              reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // frame lookup
    // ----------------------------------------------------------------
    logic [1:0]                 port_c;
    logic [vtw_pkg::PVID_W-1:0] pdef_c;
    logic                       use_def_c;
    logic [11:0]                vid_c;
    logic [2:0]                 prio_c;
    logic [vtw_pkg::NUM_ENTRIES-1:0] hit_c;
    logic                       any_hit_c;
    logic [vtw_pkg::DATA_W-1:0] ent_c;
    logic [2:0]                 memb_c;
    logic [2:0]                 untag_c;

    assign port_c = (lk_port < 2'(vtw_pkg::NUM_PORTS)) ? lk_port : 2'h0;
    assign pdef_c = pvid_q[port_c];
    assign use_def_c = !lk_tagged || (lk_vid == vtw_pkg::VID_NULL);
    assign vid_c  = use_def_c ? pdef_c[vtw_pkg::PRIO_LSB-1:vtw_pkg::VID_LSB] : lk_vid;
    assign prio_c = use_def_c ? pdef_c[vtw_pkg::PVID_W-1:vtw_pkg::PRIO_LSB] : lk_prio;

    // one comparator per entry
    for (genvar g = 0; g < vtw_pkg::NUM_ENTRIES; g++) begin : g_match
        vtw_entry_match u_match (
            .entry (vtab_q[g]),
            .vid   (vid_c),
            .hit   (hit_c[g])
        );
    end

    // lowest-numbered matching entry wins if several share a vid
    always_comb begin
        ent_c     = vtw_pkg::DATA_RST;
        any_hit_c = 1'b0;
        for (int i = vtw_pkg::NUM_ENTRIES - 1; i >= 0; i--) begin
            if (hit_c[i]) begin
                ent_c     = vtab_q[i];
                any_hit_c = 1'b1;
            end
        end
    end

    always_comb begin
        for (int p = 0; p < vtw_pkg::NUM_PORTS; p++) begin
            untag_c[p] = ent_c[vtw_pkg::P0_UNTAG_BIT + 2*p];
            memb_c[p]  = ent_c[vtw_pkg::P0_UNTAG_BIT + 2*p + 1];
        end
    end

    // registered lookup answer, one cycle after the request
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lk_done        <= 1'b0;
            lk_accept      <= 1'b0;
            lk_vid_out     <= 12'h000;
            lk_prio_out    <= 3'h0;
            lk_member_mask <= 3'h0;
            lk_strip_mask  <= 3'h0;
        end else begin
            lk_done <= lk_req;
            if (lk_req) begin
                lk_vid_out  <= vid_c;
                lk_prio_out <= prio_c;
                lk_accept <= (lk_port < 2'(vtw_pkg::NUM_PORTS)) && any_hit_c &&
                             (memb_c[port_c] || admit_nonmember_config[port_c]);
                lk_member_mask <= memb_c;
                lk_strip_mask <= {3{untag_c[port_c]}} & memb_c & egress_port_kind_config;
            end
        end
    end
endmodule : vtw_vlan_table
`default_nettype wire

/* File: dv/vtw_vlan_table_assertions.sv */
/*
 * Checker for the VLAN table block: read answer timing, reserved read bits
 * and lookup answer timing and masks.
 * Assumes it is bound to vtw_vlan_table and sees only that block's ports.
 */
`timescale 1ns/1ps
`default_nettype none
module vtw_vlan_table_assertions (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // register port
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_rvalid,
    // lookup
    input wire logic        lk_req,
    input wire logic [1:0]  lk_port,
    input wire logic        lk_done,
    input wire logic        lk_accept,
    input wire logic [2:0]  lk_member_mask,
    input wire logic [2:0]  lk_strip_mask
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // request then its one-cycle answer
    sequence s_rd_answer;
        reg_rd ##1 reg_rvalid;
    endsequence
    sequence s_lk_answer;
        lk_req ##1 lk_done;
    endsequence
    AST_READ_ANSWER: assert property (reg_rd |-> s_rd_answer)
        else $error("read answer missing");
    AST_NO_STRAY_RVALID: assert property (!reg_rd |=> !reg_rvalid)
        else $error("rvalid without read");
    AST_RSV_READ_ZERO: assert property (reg_rvalid |-> reg_rdata[31:18] == 14'h0000)
        else $error("reserved read bits set");
    AST_LOOKUP_ANSWER: assert property (lk_req |-> s_lk_answer)
        else $error("lookup answer missing");
    AST_NO_STRAY_DONE: assert property (!lk_req |=> !lk_done)
        else $error("done without request");
    AST_BAD_PORT_DROP: assert property (lk_req && lk_port == 2'h3 |=> !lk_accept)
        else $error("invalid port accepted");
    AST_STRIP_IN_DOMAIN: assert property (lk_done |-> (lk_strip_mask & ~lk_member_mask) == 3'h0)
        else $error("strip outside domain");
    // results hold between lookups
    AST_RESULT_HOLD: assert property (!lk_req |=> $stable(lk_member_mask) && $stable(lk_accept))
        else $error("lookup result moved");
endmodule : vtw_vlan_table_assertions
`default_nettype wire

/* File: dv/vtw_vlan_table_tb.sv */
/*
 * Bench for vtw_vlan_table: reset values, staging register, table
 * programming and a table of lookups. Assumes the checker file is compiled.
 */
`timescale 1ns/1ps
`default_nettype none
module vtw_vlan_table_tb;
    // ----------------------------------------
    // signals, rows and tasks
    // ----------------------------------------
    typedef struct {logic [1:0] p; logic t; logic [11:0] v; logic [2:0] pr, a, e; logic [21:0] x;} vtw_row_t;
    logic        ref_clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, lk_req = 1'h0, lk_tagged = 1'h0;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic        reg_rvalid, lk_done, lk_accept;
    logic [2:0]  adm = 3'h0, egr = 3'h0, lk_prio = 3'h0, lk_prio_out, lk_member_mask, lk_strip_mask;
    logic [1:0]  lk_port = 2'h0;
    logic [11:0] lk_vid = 12'h000, lk_vid_out;
    int          n_errors = 0, n_tests = 0;
    // port,tag,vid,prio,admit,hybrid : accept,vid,prio,members,strip
    // the last row comes in on port 3, which is never accepted even with admit set
    vtw_row_t rows[10] = '{
        '{2'h1, 1'h1, 12'h00A, 3'h3, 3'h0, 3'h7, {1'h1, 12'h00A, 3'h3, 3'h6, 3'h6}},
        '{2'h0, 1'h1, 12'h00A, 3'h3, 3'h0, 3'h7, {1'h0, 12'h00A, 3'h3, 3'h6, 3'h0}},
        '{2'h0, 1'h1, 12'h00A, 3'h3, 3'h1, 3'h7, {1'h1, 12'h00A, 3'h3, 3'h6, 3'h0}},
        '{2'h1, 1'h0, 12'h123, 3'h7, 3'h0, 3'h2, {1'h1, 12'h00A, 3'h5, 3'h6, 3'h2}},
        '{2'h1, 1'h1, 12'h000, 3'h2, 3'h0, 3'h7, {1'h1, 12'h00A, 3'h5, 3'h6, 3'h6}},
        '{2'h0, 1'h1, 12'h005, 3'h1, 3'h0, 3'h4, {1'h1, 12'h005, 3'h1, 3'h1, 3'h0}},
        '{2'h0, 1'h1, 12'h005, 3'h1, 3'h0, 3'h1, {1'h1, 12'h005, 3'h1, 3'h1, 3'h1}},
        '{2'h2, 1'h0, 12'h0AB, 3'h6, 3'h7, 3'h7, {1'h0, 12'h000, 3'h0, 3'h0, 3'h0}},
        '{2'h2, 1'h1, 12'h007, 3'h4, 3'h0, 3'h7, {1'h0, 12'h007, 3'h4, 3'h0, 3'h0}},
        '{2'h3, 1'h1, 12'h00A, 3'h3, 3'h7, 3'h7, {1'h0, 12'h00A, 3'h3, 3'h6, 3'h0}}};

    vtw_vlan_table DUT (.ref_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
        .admit_nonmember_config(adm), .egress_port_kind_config(egr), .lk_req, .lk_port, .lk_tagged,
        .lk_vid, .lk_prio, .lk_done, .lk_accept, .lk_vid_out, .lk_prio_out, .lk_member_mask, .lk_strip_mask);

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'h1;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask : wr
    // rdata lands on the edge that takes the strobe, so sample just after it
    task automatic rd(input logic [15:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        #1 v = reg_rdata;
        chk("rvalid", 32'h1, {31'h0, reg_rvalid});
    endtask : rd
    // load, command, poll; cmd is {read, port table, index}
    task automatic tbl(input logic [5:0] cmd, input logic [31:0] v);
        if (!cmd[5]) wr(vtw_pkg::REG_WR_DATA, v);
        wr(vtw_pkg::REG_CMD, {26'h0, cmd});
        for (int i = 0; i < 4; i++) begin
            rd(vtw_pkg::REG_CMD_STS, d);
            if (d[0] === 1'h0) break;
        end
        chk("pending", 32'h0, d);
        if (cmd[5]) rd(vtw_pkg::REG_RD_DATA, d);
    endtask : tbl
    task automatic look(input vtw_row_t r);
        @(posedge ref_clk);
        {lk_port, lk_tagged, lk_vid, lk_prio, adm, egr} <= {r.p, r.t, r.v, r.pr, r.a, r.e};
        lk_req <= 1'h1;
        @(posedge ref_clk);
        lk_req <= 1'h0;
        #1 chk("done", 32'h1, {31'h0, lk_done});
        chk("lookup", {10'h0, r.x},
            {10'h0, lk_accept, lk_vid_out, lk_prio_out, lk_member_mask, lk_strip_mask});
    endtask : look
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------
    // clock, watchdog and tests
    // ----------------------------------------
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'h1;
        rd(vtw_pkg::REG_WR_DATA, d);
        chk("staging reset", 32'h0, d);
        for (int p = 0; p < 3; p++) begin
            tbl(6'h30 + 6'(p), 32'h0);
            chk("default reset", 32'h0, d);
        end
        wr(vtw_pkg::REG_WR_DATA, 32'hFFFFFFFF);
        rd(vtw_pkg::REG_WR_DATA, d);
        chk("staging upper", 32'h0003FFFF, d);
        // vids avoid 3FF; entry 2 has vid zero so stays disabled
        tbl(6'h00, 32'h0002C00A);
        tbl(6'h01, 32'h00003005);
        tbl(6'h02, 32'h0003F000);
        tbl(6'h20, 32'h0);
        chk("entry 0", 32'h0002C00A, d);
        tbl(6'h21, 32'h0);
        chk("entry 1", 32'h00003005, d);
        // default vid is neither zero nor FFF
        tbl(6'h11, 32'h0003D00A);
        tbl(6'h31, 32'h0);
        chk("port default", 32'h0000500A, d);
        rd(16'h1234, d);
        chk("unmapped", 32'h0, d);
        @(posedge ref_clk);
        reg_addr <= vtw_pkg::REG_CMD;
        reg_wdata <= 32'h00000031;
        reg_wr <= 1'h1;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
        reg_addr <= vtw_pkg::REG_CMD_STS;
        reg_rd <= 1'h1;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        #1 chk("pending busy", 32'h1, reg_rdata);
        @(posedge ref_clk);
        reg_addr <= vtw_pkg::REG_CMD;
        reg_wdata <= 32'h00000031;
        reg_wr <= 1'h1;
        @(posedge ref_clk);
        reg_wdata <= 32'h00000020;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
        rd(vtw_pkg::REG_CMD, d);
        chk("busy command", 32'h00000031, d);
        foreach (rows[i]) look(rows[i]);
        @(posedge ref_clk);
        rst_n <= 1'h0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'h1;
        tbl(6'h31, 32'h0);
        chk("default rereset", 32'h0, d);
        // lookup answers were nonzero before the reset
        chk("done rereset", 32'h0, {31'h0, lk_done});
        chk("lookup rereset", 32'h0,
            {10'h0, lk_accept, lk_vid_out, lk_prio_out, lk_member_mask, lk_strip_mask});
        tally_and_finish();
    end
endmodule : vtw_vlan_table_tb

bind vtw_vlan_table vtw_vlan_table_assertions u_chk (.ref_clk, .rst_n, .reg_rd, .reg_rdata, .reg_rvalid,
    .lk_req, .lk_port, .lk_done, .lk_accept, .lk_member_mask, .lk_strip_mask);
`default_nettype wire
